// ---- csr_card_state_response_unit.sv ----
// csr_card_state_response_unit.sv: card state tracker and response formatter
// assumes: host drives command line and bus clock, both sampled here as plain inputs
`timescale 1ns/1ps
`include "csr_map.svh"
module csr_card_state_response_unit #(
  parameter int NID = `CSR_NID_CYCLES,
  parameter int NCR = `CSR_NCR_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic busClk,
  input wire logic cmdIn,
  input wire logic [31:0] cardStatus,
  input wire logic [31:0] ocrReg,
  input wire logic [127:0] cidReg,
  input wire logic [127:0] csdReg,
  input wire logic loadStateValid,
  input wire csr_pkg::csr_state_t loadState,
  output csr_pkg::csr_state_t cardState,
  output logic cmdOut,
  output logic cmdOe_n,
  output logic crcErr,
  output logic busyStart
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? `CSR_CRC_POLY : 7'h00);
    end
    return c;
  endfunction

  function automatic logic isReserved(input logic [5:0] idx);
    return (idx == `CSR_IDX_RSV_A) || (idx >= `CSR_IDX_RSV_LO && idx <= `CSR_IDX_RSV_HI)
      || (idx >= `CSR_IDX_RSV_TOP);
  endfunction

  function automatic csr_pkg::csr_dec_t decodeCmd(input csr_pkg::csr_state_t st, input logic [5:0] idx,
                                                  input logic dir);
    csr_pkg::csr_dec_t d;
    d.accept = 1'b0;
    d.nextState = st;
    d.resp = csr_pkg::RSP_NONE;
    d.useCsd = 1'b0;
    if (!isReserved(idx)) begin
      unique case (st)
        csr_pkg::ST_TRAN: begin
          d.accept = 1'b1;
          d.resp = csr_pkg::RSP_STD;
          unique case (idx)
            `CSR_IDX_STREAM_RD, `CSR_IDX_RD_SINGLE, `CSR_IDX_RD_MULTI,
            `CSR_IDX_SEND_WP: d.nextState = csr_pkg::ST_DATA;
            `CSR_IDX_STREAM_WR, `CSR_IDX_WR_SINGLE, `CSR_IDX_WR_MULTI, `CSR_IDX_PROG_CID,
            `CSR_IDX_PROG_CSD: d.nextState = csr_pkg::ST_RCV;
            `CSR_IDX_LOCK: begin
              d.nextState = csr_pkg::ST_RCV;
              d.resp = csr_pkg::RSP_BUSY;
            end
            `CSR_IDX_SET_WP, `CSR_IDX_CLR_WP, `CSR_IDX_ERASE: begin
              d.nextState = csr_pkg::ST_PRG;
              d.resp = csr_pkg::RSP_BUSY;
            end
            `CSR_IDX_BLKLEN, `CSR_IDX_BLKCNT, `CSR_IDX_TAG_START,
            `CSR_IDX_TAG_END: d.nextState = csr_pkg::ST_TRAN;
            `CSR_IDX_APP: d.nextState = st;
            `CSR_IDX_GEN: d.nextState = dir ? csr_pkg::ST_DATA : csr_pkg::ST_RCV;
            default: begin
              d.accept = 1'b0;
              d.resp = csr_pkg::RSP_NONE;
            end
          endcase
        end
        csr_pkg::ST_STBY: begin
          d.accept = 1'b1;
          unique case (idx)
            `CSR_IDX_APP: d.resp = csr_pkg::RSP_STD;
            `CSR_IDX_FAST_IO: d.resp = csr_pkg::RSP_NONE;
            `CSR_IDX_GO_IRQ: d.nextState = csr_pkg::ST_IRQ;
            `CSR_IDX_CSD: begin
              d.resp = csr_pkg::RSP_LONG;
              d.useCsd = 1'b1;
            end
            `CSR_IDX_CIDA: d.resp = csr_pkg::RSP_LONG;
            default: d.accept = 1'b0;
          endcase
        end
        csr_pkg::ST_IDLE: begin
          d.accept = (idx == `CSR_IDX_OCR);
          d.resp = d.accept ? csr_pkg::RSP_OCR : csr_pkg::RSP_NONE;
        end
        csr_pkg::ST_READY: begin
          d.accept = (idx == `CSR_IDX_CID);
          d.resp = d.accept ? csr_pkg::RSP_LONG : csr_pkg::RSP_NONE;
        end
        csr_pkg::ST_DATA, csr_pkg::ST_RCV, csr_pkg::ST_PRG, csr_pkg::ST_DIS: begin
          d.accept = (idx == `CSR_IDX_APP);
          d.resp = d.accept ? csr_pkg::RSP_STD : csr_pkg::RSP_NONE;
        end
        csr_pkg::ST_IRQ: begin
          d.accept = 1'b1;
          d.resp = (idx == `CSR_IDX_APP) ? csr_pkg::RSP_STD : csr_pkg::RSP_NONE;
          d.nextState = (idx == `CSR_IDX_APP) ? st : csr_pkg::ST_STBY;
        end
        default: d.accept = 1'b0;
      endcase
    end
    return d;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] clkSync, next_clkSync;
  logic [2:0] cmdSync, next_cmdSync;
  logic clkLevel, next_clkLevel;
  logic cmdLevel, next_cmdLevel;
  logic clkPrev, next_clkPrev;
  logic busRise;
  logic busFall;

  always_comb begin
    next_clkSync = {clkSync[1:0], busClk};
    next_cmdSync = {cmdSync[1:0], cmdIn};
    next_clkLevel = (clkSync[1] == clkSync[2]) ? clkSync[2] : clkLevel;
    next_cmdLevel = (cmdSync[1] == cmdSync[2]) ? cmdSync[2] : cmdLevel;
    next_clkPrev = clkLevel;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clkSync <= 3'h0;
      cmdSync <= 3'h7;
      clkLevel <= 1'b0;
      cmdLevel <= 1'b1;
      clkPrev <= 1'b0;
    end else begin
      clkSync <= next_clkSync;
      cmdSync <= next_cmdSync;
      clkLevel <= next_clkLevel;
      cmdLevel <= next_cmdLevel;
      clkPrev <= next_clkPrev;
    end
  end

  assign busRise = clkLevel && !clkPrev;
  assign busFall = !clkLevel && clkPrev;

  // ****************************************
  // command receive, decode and response launch
  // ****************************************
  csr_tx_if txLink ();
  csr_resp_shifter shifterInst (
    .clk(clk),
    .rst(rst),
    .tx(txLink.shifter)
  );

  csr_pkg::csr_rx_t rxState, next_rxState;
  csr_pkg::csr_state_t next_cardState;
  csr_pkg::csr_resp_t respKind, next_respKind;
  logic [47:0] shiftIn, next_shiftIn;
  logic [5:0] bitCnt, next_bitCnt;
  logic [`CSR_WAIT_W-1:0] waitCnt, next_waitCnt;
  logic [`CSR_FRAME_W-1:0] frame, next_frame;
  logic [`CSR_LEN_W-1:0] frameLen, next_frameLen;
  logic openDrain, next_openDrain;
  logic next_crcErr, next_busyStart;
  logic cmdDone, cmdOk;
  logic [47:0] fullCmd;
  logic [5:0] cmdIdx;
  logic [39:0] r1Head;
  csr_pkg::csr_dec_t dec;

  assign fullCmd = {shiftIn[46:0], cmdLevel};
  assign cmdIdx = fullCmd[`CSR_IDX_HI:`CSR_IDX_LO];
  assign cmdDone = (rxState == csr_pkg::RX_SHIFT) && busRise && (bitCnt == `CSR_CMD_LAST);
  assign cmdOk = fullCmd[46] && fullCmd[0] && (crc7(fullCmd[47:8]) == fullCmd[7:1]);
  assign dec = decodeCmd(cardState, cmdIdx, fullCmd[`CSR_ARG_LO]);
  assign r1Head = {2'b00, cmdIdx, cardStatus};

  always_comb begin
    next_rxState = rxState;
    next_cardState = cardState;
    next_respKind = respKind;
    next_shiftIn = shiftIn;
    next_bitCnt = bitCnt;
    next_waitCnt = waitCnt;
    next_frame = frame;
    next_frameLen = frameLen;
    next_openDrain = openDrain;
    next_crcErr = 1'b0;
    next_busyStart = 1'b0;
    unique case (rxState)
      csr_pkg::RX_IDLE: begin
        if (busRise && !cmdLevel) begin
          next_shiftIn = 48'h0;
          next_bitCnt = 6'h01;
          next_rxState = csr_pkg::RX_SHIFT;
        end
      end
      csr_pkg::RX_SHIFT: begin
        if (busRise) begin
          next_shiftIn = fullCmd;
          next_bitCnt = bitCnt + 6'h01;
        end
        if (cmdDone) begin
          next_rxState = csr_pkg::RX_IDLE;
          if (!cmdOk || !dec.accept) begin
            next_crcErr = !cmdOk;
            if (cardState == csr_pkg::ST_IRQ) begin
              next_cardState = csr_pkg::ST_STBY;
            end
          end else begin
            next_cardState = dec.nextState;
            next_respKind = dec.resp;
            next_openDrain = (dec.resp == csr_pkg::RSP_OCR) || (cmdIdx == `CSR_IDX_CID);
            next_waitCnt = next_openDrain ? `CSR_WAIT_W'(NID) : `CSR_WAIT_W'(NCR);
            next_frameLen = `CSR_LEN_SHORT;
            unique case (dec.resp)
              csr_pkg::RSP_STD, csr_pkg::RSP_BUSY: begin
                next_frame = {r1Head, crc7(r1Head), 1'b1, `CSR_PAD_SHORT'(0)};
              end
              csr_pkg::RSP_OCR: begin
                next_frame = {2'b00, `CSR_ALL_ONES6, ocrReg, `CSR_ALL_ONES7, 1'b1, `CSR_PAD_SHORT'(0)};
              end
              csr_pkg::RSP_LONG: begin
                next_frameLen = `CSR_LEN_LONG;
                next_frame = {2'b00, `CSR_ALL_ONES6, dec.useCsd ? csdReg[127:1] : cidReg[127:1], 1'b1};
              end
              default: next_frame = frame;
            endcase
            if (dec.resp != csr_pkg::RSP_NONE) begin
              next_rxState = csr_pkg::RX_WAIT;
            end
          end
        end
      end
      csr_pkg::RX_WAIT: begin
        if (busRise) begin
          if (waitCnt <= `CSR_WAIT_W'(1)) begin
            next_rxState = csr_pkg::RX_SEND;
          end else begin
            next_waitCnt = waitCnt - `CSR_WAIT_W'(1);
          end
        end
      end
      csr_pkg::RX_SEND: begin
        if (!txLink.busy && cmdOe_n && waitCnt == '0) begin
          next_rxState = csr_pkg::RX_IDLE;
          next_busyStart = (respKind == csr_pkg::RSP_BUSY);
        end else if (txLink.busy) begin
          next_waitCnt = '0;
        end
      end
      default: next_rxState = csr_pkg::RX_IDLE;
    endcase
    if (loadStateValid && rxState != csr_pkg::RX_SHIFT) begin
      next_cardState = loadState;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxState <= csr_pkg::RX_IDLE;
      cardState <= csr_pkg::ST_IDLE;
      respKind <= csr_pkg::RSP_NONE;
      shiftIn <= 48'h0;
      bitCnt <= 6'h00;
      waitCnt <= '0;
      frame <= '0;
      frameLen <= '0;
      openDrain <= 1'b0;
      crcErr <= 1'b0;
      busyStart <= 1'b0;
    end else begin
      rxState <= next_rxState;
      cardState <= next_cardState;
      respKind <= next_respKind;
      shiftIn <= next_shiftIn;
      bitCnt <= next_bitCnt;
      waitCnt <= next_waitCnt;
      frame <= next_frame;
      frameLen <= next_frameLen;
      openDrain <= next_openDrain;
      crcErr <= next_crcErr;
      busyStart <= next_busyStart;
    end
  end

  assign txLink.frame = frame;
  assign txLink.len = frameLen;
  assign txLink.openDrain = openDrain;
  assign txLink.start = (rxState == csr_pkg::RX_SEND) && (waitCnt != '0);
  assign txLink.fallEdge = busFall;
  assign cmdOut = txLink.lineOut;
  assign cmdOe_n = txLink.lineOe_n;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic tranOk;
  assign tranOk = cmdDone && cmdOk && cardState == csr_pkg::ST_TRAN;

  AST_TRAN_READ: assert property (tranOk && cmdIdx == `CSR_IDX_RD_SINGLE |=> cardState == csr_pkg::ST_DATA)
    else $error("read in tran did not reach data");
  AST_TRAN_WRITE: assert property (tranOk && cmdIdx == `CSR_IDX_WR_SINGLE |=> cardState == csr_pkg::ST_RCV)
    else $error("write in tran did not reach rcv");
  AST_TRAN_PRG: assert property (tranOk && cmdIdx == `CSR_IDX_ERASE |=> cardState == csr_pkg::ST_PRG)
    else $error("erase in tran did not reach prg");
  AST_TRAN_STAY: assert property (tranOk && cmdIdx == `CSR_IDX_BLKLEN |=> cardState == csr_pkg::ST_TRAN)
    else $error("block length left tran");
  AST_APP_KEEP: assert property (cmdDone && cmdOk && cmdIdx == `CSR_IDX_APP |=> $stable(cardState))
    else $error("application prefix changed state");
  AST_GEN_DIR: assert property (tranOk && cmdIdx == `CSR_IDX_GEN
                                |=> cardState == ($past(fullCmd[`CSR_ARG_LO]) ? csr_pkg::ST_DATA : csr_pkg::ST_RCV))
    else $error("general command direction wrong");
  AST_GO_IRQ: assert property (cmdDone && cmdOk && cardState == csr_pkg::ST_STBY && cmdIdx == `CSR_IDX_GO_IRQ
                               && !loadStateValid |=> cardState == csr_pkg::ST_IRQ)
    else $error("go-interrupt did not reach irq");
  AST_START_ZERO: assert property ($fell(cmdOe_n) |-> !cmdOut)
    else $error("response did not start with zero");
  AST_CRC_KEEP: assert property (cmdDone && !cmdOk && cardState != csr_pkg::ST_IRQ |=> $stable(cardState))
    else $error("crc error changed state");
  AST_NO_RESP: assert property (cmdDone && !dec.accept |=> rxState == csr_pkg::RX_IDLE [*2])
    else $error("unaccepted command started a response");
  AST_OCR_FRAME: assert property (rxState == csr_pkg::RX_WAIT && respKind == csr_pkg::RSP_OCR
                                  |-> frame[133:128] == `CSR_ALL_ONES6 && frame[95:89] == `CSR_ALL_ONES7)
    else $error("ocr frame reserved fields wrong");

  COV_READ: cover property (tranOk && cmdIdx == `CSR_IDX_RD_SINGLE);
  COV_LONG: cover property (rxState == csr_pkg::RX_SEND && respKind == csr_pkg::RSP_LONG);
  COV_IRQ_EXIT: cover property (cardState == csr_pkg::ST_IRQ ##1 cardState == csr_pkg::ST_STBY);
endmodule

// ---- csr_map.svh ----
// csr_map.svh: offsets, field positions and counts of the card state and response unit
// assumes: included by bare name from every design file that needs the figures
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// ****************************************
// frame geometry
// ****************************************
`define CSR_CMD_LAST 6'h2F
`define CSR_LEN_W 8
`define CSR_LEN_SHORT 8'h30
`define CSR_LEN_LONG 8'h88
`define CSR_FRAME_W 136
`define CSR_IDX_HI 45
`define CSR_IDX_LO 40
`define CSR_ARG_HI 39
`define CSR_ARG_LO 8
`define CSR_ALL_ONES6 6'h3F
`define CSR_ALL_ONES7 7'h7F
`define CSR_CRC_POLY 7'h09
`define CSR_PAD_SHORT 88

// ****************************************
// timing in bus clock cycles
// ****************************************
`define CSR_NID_CYCLES 5
`define CSR_NCR_CYCLES 2
`define CSR_WAIT_W 4

// ****************************************
// command indices
// ****************************************
`define CSR_IDX_OCR 6'h01
`define CSR_IDX_CID 6'h02
`define CSR_IDX_CSD 6'h09
`define CSR_IDX_CIDA 6'h0A
`define CSR_IDX_STREAM_RD 6'h0B
`define CSR_IDX_BLKLEN 6'h10
`define CSR_IDX_RD_SINGLE 6'h11
`define CSR_IDX_RD_MULTI 6'h12
`define CSR_IDX_STREAM_WR 6'h14
`define CSR_IDX_BLKCNT 6'h17
`define CSR_IDX_WR_SINGLE 6'h18
`define CSR_IDX_WR_MULTI 6'h19
`define CSR_IDX_PROG_CID 6'h1A
`define CSR_IDX_PROG_CSD 6'h1B
`define CSR_IDX_SET_WP 6'h1C
`define CSR_IDX_CLR_WP 6'h1D
`define CSR_IDX_SEND_WP 6'h1E
`define CSR_IDX_TAG_START 6'h23
`define CSR_IDX_TAG_END 6'h24
`define CSR_IDX_ERASE 6'h26
`define CSR_IDX_FAST_IO 6'h27
`define CSR_IDX_GO_IRQ 6'h28
`define CSR_IDX_RSV_A 6'h29
`define CSR_IDX_LOCK 6'h2A
`define CSR_IDX_RSV_LO 6'h2B
`define CSR_IDX_RSV_HI 6'h36
`define CSR_IDX_APP 6'h37
`define CSR_IDX_GEN 6'h38
`define CSR_IDX_RSV_TOP 6'h39

`endif

// ---- csr_pkg.sv ----
// csr_pkg.sv: types of the card state and response unit
// assumes: nothing beyond a SystemVerilog compiler
package csr_pkg;

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_READY = 11'h002,
    ST_IDENT = 11'h004,
    ST_STBY = 11'h008,
    ST_TRAN = 11'h010,
    ST_DATA = 11'h020,
    ST_RCV = 11'h040,
    ST_PRG = 11'h080,
    ST_DIS = 11'h100,
    ST_INA = 11'h200,
    ST_IRQ = 11'h400
  } csr_state_t;

  typedef enum logic [4:0] {
    RSP_NONE = 5'h01,
    RSP_STD = 5'h02,
    RSP_BUSY = 5'h04,
    RSP_LONG = 5'h08,
    RSP_OCR = 5'h10
  } csr_resp_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_SHIFT = 4'h2,
    RX_WAIT = 4'h4,
    RX_SEND = 4'h8
  } csr_rx_t;

  typedef struct packed {
    logic accept;
    csr_state_t nextState;
    csr_resp_t resp;
    logic useCsd;
  } csr_dec_t;

endpackage

// ---- csr_tx_if.sv ----
// csr_tx_if.sv: link between the command tracker and the response shifter
// assumes: both ends run on the same clock
`timescale 1ns/1ps
`include "csr_map.svh"
interface csr_tx_if;
  logic [`CSR_FRAME_W-1:0] frame;
  logic [`CSR_LEN_W-1:0] len;
  logic openDrain;
  logic start;
  logic fallEdge;
  logic busy;
  logic lineOut;
  logic lineOe_n;
  modport ctrl (output frame, output len, output openDrain, output start, output fallEdge,
                input busy, input lineOut, input lineOe_n);
  modport shifter (input frame, input len, input openDrain, input start, input fallEdge,
                   output busy, output lineOut, output lineOe_n);
endinterface

// ---- csr_resp_shifter.sv ----
// csr_resp_shifter.sv: shifts a response frame out on the command line
// assumes: fallEdge pulses once per falling edge of the bus clock
`timescale 1ns/1ps
`include "csr_map.svh"
module csr_resp_shifter (
  input wire logic clk,
  input wire logic rst,
  csr_tx_if.shifter tx
);
  logic [`CSR_FRAME_W-1:0] shift, next_shift;
  logic [`CSR_LEN_W-1:0] remain, next_remain;
  logic busy, next_busy;
  logic lineOut, next_lineOut;
  logic drive, next_drive;
  logic openDrain, next_openDrain;

  // ****************************************
  // shifter
  // ****************************************
  always_comb begin
    next_shift = shift;
    next_remain = remain;
    next_busy = busy;
    next_lineOut = lineOut;
    next_drive = drive;
    next_openDrain = openDrain;
    if (tx.start && !busy) begin
      next_shift = tx.frame;
      next_remain = tx.len;
      next_busy = 1'b1;
      next_openDrain = tx.openDrain;
    end else if (busy && tx.fallEdge) begin
      if (remain != '0) begin
        next_lineOut = shift[`CSR_FRAME_W-1];
        next_drive = 1'b1;
        next_shift = {shift[`CSR_FRAME_W-2:0], 1'b0};
        next_remain = remain - 8'h01;
      end else begin
        next_drive = 1'b0;
        next_lineOut = 1'b1;
        next_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift <= '0;
      remain <= '0;
      busy <= 1'b0;
      lineOut <= 1'b1;
      drive <= 1'b0;
      openDrain <= 1'b0;
    end else begin
      shift <= next_shift;
      remain <= next_remain;
      busy <= next_busy;
      lineOut <= next_lineOut;
      drive <= next_drive;
      openDrain <= next_openDrain;
    end
  end

  // open-drain mode releases the line for ones
  assign tx.busy = busy;
  assign tx.lineOut = lineOut;
  assign tx.lineOe_n = !(drive && (!openDrain || !lineOut));
endmodule

// ---- csr_host_model.sv ----
// csr_host_model.sv: host side of the command line, makes the bus clock and sends commands
// assumes: the command line has a pull-up; the card drives it only while cmdOe_n is low
`timescale 1ns/1ps
module csr_host_model (
  input wire logic cmdOut,
  input wire logic cmdOe_n,
  output logic busClk,
  output logic cmdIn,
  output logic respOk
);
  logic hostOe;
  logic hostBit;
  // wired level of the line, pulled up when nobody drives
  assign cmdIn = (cmdOe_n === 1'b0) ? cmdOut : (hostOe ? hostBit : 1'b1);
  initial begin
    busClk = 1'b0;
    hostOe = 1'b0;
    hostBit = 1'b1;
    respOk = 1'b1;
  end
  // send one command msb first, then clock out a response of len bits
  task automatic xfer(input logic [47:0] f, input int len, output logic [135:0] rsp, output int n,
                      output int wr);
    rsp = '0;
    n = 0;
    wr = 0;
    hostOe = 1'b1;
    for (int k = 47; k >= 0; k--) begin
      hostBit = f[k];
      #80 busClk = 1'b1;
      #80 busClk = 1'b0;
    end
    hostOe = 1'b0;
    hostBit = 1'b1;
    for (int k = 1; k <= 10 && n == 0; k++) begin
      #80 busClk = 1'b1;
      if (cmdIn === 1'b0) begin
        wr = k;
        n = 1;
      end
      #80 busClk = 1'b0;
    end
    while (n > 0 && n < len) begin
      #80 busClk = 1'b1;
      rsp = {rsp[134:0], cmdIn};
      n++;
      #80 busClk = 1'b0;
    end
    respOk = (n == len) && (len == 0 || (rsp[len-2] === 1'b0 && rsp[0] === 1'b1));
    repeat (2) begin
      #80 busClk = 1'b1;
      #80 busClk = 1'b0;
    end
  endtask
endmodule

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench of the card state and response unit
// assumes: class-0 states are loaded through loadState before each command
`timescale 1ns/1ps
module tb_top;
  localparam int NID = 5;
  localparam int NCR = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic busClk, cmdIn, respOk, loadStateValid, cmdOut, cmdOe_n, crcErr, busyStart;
  logic [31:0] cardStatus, ocrReg;
  logic [127:0] cidReg, csdReg;
  csr_pkg::csr_state_t loadState, cardState;
  int err_count = 0;
  int comparisons = 0;
  int busyCnt = 0;
  int crcCnt = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (busyStart === 1'b1) busyCnt <= busyCnt + 1;
    if (crcErr === 1'b1) crcCnt <= crcCnt + 1;
  end
  csr_card_state_response_unit #(.NID(NID), .NCR(NCR)) dut (.clk(clk), .rst(rst), .busClk(busClk),
    .cmdIn(cmdIn), .cardStatus(cardStatus), .ocrReg(ocrReg), .cidReg(cidReg), .csdReg(csdReg),
    .loadStateValid(loadStateValid), .loadState(loadState), .cardState(cardState), .cmdOut(cmdOut),
    .cmdOe_n(cmdOe_n), .crcErr(crcErr), .busyStart(busyStart));
  csr_host_model host (.cmdOut(cmdOut), .cmdOe_n(cmdOe_n), .busClk(busClk), .cmdIn(cmdIn), .respOk(respOk));
  // ****************************************
  // expectations and compares
  // ****************************************
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int k = 39; k >= 0; k--) begin
      fb = d[k] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  // next state and response kind: 0 none, 1 standard, 2 long id, 3 long specific, 4 ocr
  function automatic int expect_of(input csr_pkg::csr_state_t s, input logic [5:0] i, input logic a0,
                                   output csr_pkg::csr_state_t n);
    int r;
    n = s;
    r = (i == 6'h37 && s != csr_pkg::ST_IDLE && s != csr_pkg::ST_READY) ? 1 : 0;
    case (s)
      csr_pkg::ST_TRAN: begin
        r = 1;
        case (i)
          6'h0B, 6'h11, 6'h12, 6'h1E: n = csr_pkg::ST_DATA;
          6'h14, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h2A: n = csr_pkg::ST_RCV;
          6'h1C, 6'h1D, 6'h26: n = csr_pkg::ST_PRG;
          6'h10, 6'h17, 6'h23, 6'h24, 6'h37: r = 1;
          6'h38: n = a0 ? csr_pkg::ST_DATA : csr_pkg::ST_RCV;
          default: r = 0;
        endcase
      end
      csr_pkg::ST_STBY: begin
        if (i == 6'h28) n = csr_pkg::ST_IRQ;
        if (i == 6'h09) r = 3;
        if (i == 6'h0A) r = 2;
      end
      csr_pkg::ST_IDLE: r = (i == 6'h01) ? 4 : 0;
      csr_pkg::ST_READY: r = (i == 6'h02) ? 2 : 0;
      csr_pkg::ST_IRQ: if (i != 6'h37) n = csr_pkg::ST_STBY;
      default: ;
    endcase
    return r;
  endfunction
  task automatic fail(input string m);
    err_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_state(input csr_pkg::csr_state_t g, input csr_pkg::csr_state_t e);
    comparisons++;
    if (g !== e) fail("card state differs");
  endtask
  task automatic chk_bits(input logic [135:0] g, input logic [135:0] e);
    comparisons++;
    if (g !== e) fail("response bits differ");
  endtask
  task automatic chk_num(input int g, input int e);
    comparisons++;
    if (g != e) fail("count or delay differs");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one command in a loaded state, then all of its effects
  task automatic run(input csr_pkg::csr_state_t s, input logic [5:0] i, input logic [31:0] a, input logic bad);
    csr_pkg::csr_state_t en;
    int r, len, b0, c0, n, wr;
    logic [135:0] ex, got;
    logic [39:0] body;
    body = {2'b01, i, a};
    r = expect_of(s, i, a[0], en);
    if (bad) r = 0;
    if (bad) en = (s == csr_pkg::ST_IRQ) ? csr_pkg::ST_STBY : s;
    ex = '0;
    len = (r == 0) ? 0 : ((r == 2 || r == 3) ? 136 : 48);
    if (r == 1) ex[47:0] = {2'b00, i, cardStatus, crc7({2'b00, i, cardStatus}), 1'b1};
    if (r == 2) ex = {2'b00, 6'h3F, cidReg[127:1], 1'b1};
    if (r == 3) ex = {2'b00, 6'h3F, csdReg[127:1], 1'b1};
    if (r == 4) ex[47:0] = {2'b00, 6'h3F, ocrReg, 7'h7F, 1'b1};
    @(posedge clk) #1;
    loadState = s;
    loadStateValid = 1'b1;
    @(posedge clk) #1;
    loadStateValid = 1'b0;
    b0 = busyCnt;
    c0 = crcCnt;
    host.xfer({body, crc7(body) ^ {6'h00, bad}, 1'b1}, len, got, n, wr);
    repeat (8) @(posedge clk);
    chk_state(cardState, en);
    chk_bits(got, ex);
    chk_num(n, len);
    chk_bits({135'h0, respOk}, 136'h1);
    if (len > 0) chk_num(wr, (r == 4 || (r == 2 && s == csr_pkg::ST_READY)) ? NID + 1 : NCR + 1);
    chk_num(busyCnt - b0, (s == csr_pkg::ST_TRAN && i inside {6'h1C, 6'h1D, 6'h26, 6'h2A} && !bad) ? 1 : 0);
    chk_num(crcCnt - c0, bad ? 1 : 0);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  logic [5:0] tl[18] = '{6'h0B, 6'h11, 6'h12, 6'h1E, 6'h14, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h2A, 6'h1C,
                         6'h1D, 6'h26, 6'h10, 6'h17, 6'h23, 6'h24, 6'h38};
  initial begin
    void'($urandom(96185));
    loadStateValid = 1'b0;
    loadState = csr_pkg::ST_IDLE;
    cardStatus = $urandom();
    ocrReg = $urandom();
    cidReg = {$urandom(), $urandom(), $urandom(), $urandom()};
    csdReg = {$urandom(), $urandom(), $urandom(), $urandom()};
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    foreach (tl[k]) run(csr_pkg::ST_TRAN, tl[k], $urandom(), 1'b0);
    run(csr_pkg::ST_TRAN, 6'h38, 32'h0000_0001, 1'b0);
    run(csr_pkg::ST_DATA, 6'h37, $urandom(), 1'b0);
    run(csr_pkg::ST_IRQ, 6'h37, $urandom(), 1'b0);
    run(csr_pkg::ST_STBY, 6'h28, $urandom(), 1'b0);
    run(csr_pkg::ST_IRQ, 6'h11, $urandom(), 1'b0);
    run(csr_pkg::ST_STBY, 6'h27, $urandom(), 1'b0);
    run(csr_pkg::ST_IDLE, 6'h01, $urandom(), 1'b0);
    run(csr_pkg::ST_READY, 6'h02, $urandom(), 1'b0);
    run(csr_pkg::ST_STBY, 6'h09, $urandom(), 1'b0);
    run(csr_pkg::ST_TRAN, 6'h3C, $urandom(), 1'b0);
    run(csr_pkg::ST_TRAN, 6'h11, $urandom(), 1'b1);
    run(csr_pkg::ST_IRQ, 6'h37, $urandom(), 1'b1);
    run(csr_pkg::ST_PRG, tl[$urandom_range(17)], $urandom(), 1'b0);
    end_of_test();
  end
endmodule
